// *** src/tws_consts.vh ***
// Constants of the two-wire slave: register indices, field positions, reset values.
// Assumes byte addresses on the register bus are four times the register index.
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// ****************************************
// Register indices
// ****************************************
`define TWS_IDX_CTRL        6'h08
`define TWS_IDX_CMD         6'h0A
`define TWS_IDX_FLAGS       6'h0B
`define TWS_IDX_OWN_ID      6'h0C
`define TWS_IDX_BYTE_PORT   6'h0D
`define TWS_IDX_SECOND_ID   6'h0E
`define TWS_IDX_IRQ_STATUS  6'h0F
`define TWS_IDX_IRQ_MASK    6'h10

// ****************************************
// Control register fields
// ****************************************
`define TWS_CTRL_ENABLE     0
`define TWS_CTRL_AUTO_HS    1
`define TWS_CTRL_PROMISC    2
`define TWS_CTRL_HALT_PERM  5
`define TWS_CTRL_MASTER_EN  7
`define TWS_CTRL_RESET      8'h00

// ****************************************
// Command register fields and codes
// ****************************************
`define TWS_CMD_REPLY_BIT   2
`define TWS_CMD_NOACT       2'h0
`define TWS_CMD_COMPTRANS   2'h2
`define TWS_CMD_RESPONSE    2'h3

// ****************************************
// State flag positions
// ****************************************
`define TWS_FLG_DATA        7
`define TWS_FLG_MATCH_HALT  6
`define TWS_FLG_STRETCH     5
`define TWS_FLG_RXACK       4
`define TWS_FLG_COLL        3
`define TWS_FLG_BUSERR      2
`define TWS_FLG_DIR         1
`define TWS_FLG_CAUSE       0

// ****************************************
// Interrupt status bits and reset values
// ****************************************
`define TWS_IRQ_MATCH       0
`define TWS_IRQ_STOP        1
`define TWS_IRQ_DATA        2
`define TWS_IRQ_BUSERR      3
`define TWS_REG_RESET       8'h00
`define TWS_GENERAL_CALL_ID 7'h00

`endif

// *** src/tws_sync_edge.v ***
// Two-flop synchroniser with edge detection for one bus line.
// Assumes the input is asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/1ps
module tws_sync_edge #(
	parameter RESET_LEVEL = 1'b1
) (
	// Clock and reset
	input  wire clk,
	input  wire reset,
	// Line in
	input  wire line_in,
	// Synchronised level and edges
	output reg  level,
	output wire rise,
	output wire fall
);
	reg stage1;
	reg stage2;

	always @(posedge clk) begin
		if (reset) begin
			stage1 <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			level  <= RESET_LEVEL;
		end else begin
			stage1 <= line_in;
			stage2 <= stage1;
			level  <= stage2;
		end
	end

	assign rise = stage2 & ~level;
	assign fall = ~stage2 & level;
endmodule // tws_sync_edge

// *** src/tws_slave.v ***
// Two-wire bus slave: ID matching, direction and match-or-halt status, byte port, bus error.
// Assumes open-drain SCL/SDA resolved outside, mclk at least four times the SCL rate.
//
// Function
// - Bus errors are flagged only while master side enabled; clock four times SCL.
// - Direction bit holds read/write bit of last accepted address packet.
// - Cause bit reads 0 for Stop, 1 for ID match, when flag set.
// - Accepted address packet sets match-or-halt flag and cause bit to one.
// - Incoming seven-bit ID compares against own-ID bits 7 to 1.
// - Own-ID bit 0 enables acceptance of general call ID 0x00.
// - Auto-handshake: byte port read during stretch performs reply action and resumes.
// - Dual-ID select zero: second register bits 7:1 mask own-ID bits.
// - Dual-ID select one: accept own ID and second ID both.
// - Promiscuous match accepts every received ID.
// - Stop sets match-or-halt flag only when halt-flag permit is one.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_slave (
	// Clock and reset
	input  wire       mclk,
	input  wire       reset,
	// Avalon-MM slave
	input  wire [7:0] address,
	input  wire       read,
	input  wire       write,
	input  wire [3:0] byteenable,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg        waitrequest,
	// Interrupt
	output reg        irq,
	// Bus lines
	input  wire       scl_i,
	output reg        scl_o,
	output reg        scl_oe,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe
);
	// ****************************************
	// States
	// ****************************************
	localparam ST_IDLE      = 3'h0;
	localparam ST_ADDR      = 3'h1;
	localparam ST_ADDR_HOLD = 3'h2;
	localparam ST_ACK       = 3'h3;
	localparam ST_RX        = 3'h4;
	localparam ST_DATA_HOLD = 3'h5;
	localparam ST_TX        = 3'h6;
	localparam ST_TX_ACK    = 3'h7;

	// ****************************************
	// Declarations
	// ****************************************
	reg  [7:0] ctrl;
	reg        reply_bit_choice;
	reg  [7:0] own_id_reg;
	reg  [7:0] second_id_or_mask_reg;
	reg  [7:0] slave_byte_port;
	reg  [7:0] irq_status;
	reg  [7:0] irq_mask;
	reg        data_flag;
	reg        match_or_halt_flag;
	reg        match_or_halt_cause;
	reg        rxack;
	reg        buserr;
	reg        dir;
	reg  [2:0] state;
	reg  [3:0] cnt;
	reg  [7:0] shifter;
	reg        end_after;
	reg  [7:0] captured;
	wire       scl_lvl;
	wire       scl_rise;
	wire       scl_fall;
	wire       sda_lvl;
	wire       sda_rise;
	wire       sda_fall;
	wire [5:0] idx;
	wire       aligned;
	wire       wr_acc;
	wire       rd_acc;
	wire       scl_stretch_flag;
	wire       enable;
	wire       auto_handshake_mode;
	wire       promiscuous_match;
	wire       halt_flag_permit;
	wire       master_enable;
	wire       start_det;
	wire       stop_det;
	wire [6:0] rx_id;
	wire [6:0] id_compare_mask;
	wire       dual_id_select;
	wire       id_match;
	wire       port_rd;
	wire       port_wr;
	wire       cmd_wr;
	wire [1:0] cmd;
	wire       resume;
	wire       set_buserr;
	wire       reply_now;
	reg  [7:0] flags_view;
	reg  [7:0] next_read;
	reg        ev_match;
	reg        ev_stop;
	reg        ev_data;

	// ****************************************
	// Line synchronisers
	// ****************************************
	tws_sync_edge #(.RESET_LEVEL(1'b1)) u_scl_sync (
		.clk     (mclk),
		.reset   (reset),
		.line_in (scl_i),
		.level   (scl_lvl),
		.rise    (scl_rise),
		.fall    (scl_fall)
	);

	tws_sync_edge #(.RESET_LEVEL(1'b1)) u_sda_sync (
		.clk     (mclk),
		.reset   (reset),
		.line_in (sda_i),
		.level   (sda_lvl),
		.rise    (sda_rise),
		.fall    (sda_fall)
	);

	assign start_det = scl_lvl & sda_fall;
	assign stop_det  = scl_lvl & sda_rise;

	// ****************************************
	// Register decode
	// ****************************************
	assign idx     = address[7:2];
	assign aligned = (address[1:0] == 2'h0);
	assign wr_acc  = write & ~waitrequest & aligned & byteenable[0];
	assign rd_acc  = read & ~waitrequest & aligned;

	assign enable              = ctrl[`TWS_CTRL_ENABLE];
	assign auto_handshake_mode = ctrl[`TWS_CTRL_AUTO_HS];
	assign promiscuous_match   = ctrl[`TWS_CTRL_PROMISC];
	assign halt_flag_permit    = ctrl[`TWS_CTRL_HALT_PERM];
	assign master_enable       = ctrl[`TWS_CTRL_MASTER_EN];
	assign scl_stretch_flag    = scl_oe;

	assign port_rd = rd_acc & (idx == `TWS_IDX_BYTE_PORT);
	assign port_wr = wr_acc & (idx == `TWS_IDX_BYTE_PORT);
	assign cmd_wr  = wr_acc & (idx == `TWS_IDX_CMD);
	assign cmd     = cmd_wr ? writedata[1:0] : `TWS_CMD_NOACT;

	// Auto handshake resumes on a byte port read, or a byte port write in read direction; otherwise a command must be written
	assign resume = scl_oe & ((auto_handshake_mode & (port_rd | (port_wr & dir)))
		| (cmd == `TWS_CMD_RESPONSE) | (cmd == `TWS_CMD_COMPTRANS));
	// A reply bit written together with a command applies to that command
	assign reply_now = cmd_wr ? writedata[`TWS_CMD_REPLY_BIT] : reply_bit_choice;

	// ****************************************
	// ID matching
	// ****************************************
	assign rx_id           = shifter[7:1];
	assign id_compare_mask = second_id_or_mask_reg[7:1];
	assign dual_id_select  = second_id_or_mask_reg[0];
	assign id_match = promiscuous_match
		| (own_id_reg[0] & (rx_id == `TWS_GENERAL_CALL_ID))
		| (dual_id_select ? ((rx_id == own_id_reg[7:1]) | (rx_id == id_compare_mask))
		: (((rx_id ^ own_id_reg[7:1]) & ~id_compare_mask) == 7'h00));

	// Bus error detector belongs to the master side; a Start or Stop inside a byte is illegal
	assign set_buserr = master_enable & enable & (start_det | stop_det)
		& (cnt != 4'h0) & ((state == ST_ADDR) | (state == ST_RX) | (state == ST_TX));

	// ****************************************
	// Bus protocol engine
	// ****************************************
	always @(posedge mclk) begin
		if (reset) begin
			state     <= ST_IDLE;
			cnt       <= 4'h0;
			shifter   <= 8'h00;
			end_after <= 1'b0;
			scl_oe    <= 1'b0;
			sda_oe    <= 1'b0;
			scl_o     <= 1'b0;
			sda_o     <= 1'b0;
			dir       <= 1'b0;
			rxack     <= 1'b0;
			slave_byte_port <= `TWS_REG_RESET;
			ev_match  <= 1'b0;
			ev_stop   <= 1'b0;
			ev_data   <= 1'b0;
		end else begin
			ev_match <= 1'b0;
			ev_stop  <= 1'b0;
			ev_data  <= 1'b0;
			if (port_wr)
				slave_byte_port <= writedata[7:0];
			if (!enable) begin
				state  <= ST_IDLE;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_det) begin
				state  <= ST_IDLE;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				ev_stop <= halt_flag_permit;
			end else if (start_det) begin
				state  <= ST_ADDR;
				cnt    <= 4'h0;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					cnt <= 4'h0;
				end
				ST_ADDR: begin
					if (scl_rise && cnt < 4'h8) begin
						shifter <= {shifter[6:0], sda_lvl};
						cnt     <= cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						if (id_match) begin
							dir      <= shifter[0];
							ev_match <= 1'b1;
							scl_oe   <= 1'b1;
							state    <= ST_ADDR_HOLD;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ADDR_HOLD, ST_DATA_HOLD: begin
					if (resume) begin
						end_after <= (cmd == `TWS_CMD_COMPTRANS);
						if (state == ST_DATA_HOLD && dir) begin
							if (cmd == `TWS_CMD_COMPTRANS) begin
								state <= ST_IDLE;
							end else begin
								shifter <= port_wr ? writedata[7:0] : slave_byte_port;
								sda_oe  <= port_wr ? ~writedata[7] : ~slave_byte_port[7];
								cnt     <= 4'h0;
								state   <= ST_TX;
							end
						end else begin
							sda_oe <= ~reply_now;
							state  <= ST_ACK;
						end
						scl_oe <= 1'b0;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						cnt    <= 4'h0;
						if (reply_bit_choice || end_after) begin
							state <= ST_IDLE;
						end else if (dir) begin
							scl_oe  <= 1'b1;
							ev_data <= 1'b1;
							state   <= ST_DATA_HOLD;
						end else begin
							state <= ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_rise && cnt < 4'h8) begin
						shifter <= {shifter[6:0], sda_lvl};
						cnt     <= cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						slave_byte_port <= shifter;
						scl_oe  <= 1'b1;
						ev_data <= 1'b1;
						state   <= ST_DATA_HOLD;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt == 4'h7) begin
							sda_oe <= 1'b0;
							state  <= ST_TX_ACK;
						end else begin
							sda_oe  <= ~shifter[6];
							shifter <= {shifter[6:0], 1'b0};
							cnt     <= cnt + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						rxack <= sda_lvl;
					end else if (scl_fall) begin
						if (rxack) begin
							state <= ST_IDLE;
						end else begin
							scl_oe  <= 1'b1;
							ev_data <= 1'b1;
							state   <= ST_DATA_HOLD;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	always @(posedge mclk) begin
		if (reset) begin
			data_flag           <= 1'b0;
			match_or_halt_flag  <= 1'b0;
			match_or_halt_cause <= 1'b0;
			buserr              <= 1'b0;
		end else begin
			// Clears come first so that a simultaneous event still sets
			if (port_rd || port_wr || cmd_wr) begin
				data_flag          <= 1'b0;
				match_or_halt_flag <= 1'b0;
			end
			if (wr_acc && idx == `TWS_IDX_FLAGS && writedata[`TWS_FLG_BUSERR])
				buserr <= 1'b0;
			if (ev_data)
				data_flag <= 1'b1;
			if (ev_match) begin
				match_or_halt_flag  <= 1'b1;
				match_or_halt_cause <= 1'b1;
			end else if (ev_stop) begin
				match_or_halt_flag  <= 1'b1;
				match_or_halt_cause <= 1'b0;
			end
			if (set_buserr)
				buserr <= 1'b1;
		end
	end

	// ****************************************
	// Register bus and interrupt
	// ****************************************
	always @* begin
		flags_view = {data_flag, match_or_halt_flag, scl_stretch_flag, rxack,
			1'b0, buserr, dir, match_or_halt_cause};
		case (idx)
		`TWS_IDX_CTRL:       next_read = ctrl;
		`TWS_IDX_CMD:        next_read = {5'h00, reply_bit_choice, 2'h0};
		`TWS_IDX_FLAGS:      next_read = flags_view;
		`TWS_IDX_OWN_ID:     next_read = own_id_reg;
		`TWS_IDX_BYTE_PORT:  next_read = slave_byte_port;
		`TWS_IDX_SECOND_ID:  next_read = second_id_or_mask_reg;
		`TWS_IDX_IRQ_STATUS: next_read = irq_status;
		`TWS_IDX_IRQ_MASK:   next_read = irq_mask;
		default:             next_read = 8'h00;
		endcase
		if (!aligned)
			next_read = 8'h00;
	end

	always @(posedge mclk) begin
		if (reset) begin
			waitrequest           <= 1'b1;
			readdata              <= 32'h0000_0000;
			captured              <= 8'h00;
			ctrl                  <= `TWS_CTRL_RESET;
			reply_bit_choice      <= 1'b0;
			own_id_reg            <= `TWS_REG_RESET;
			second_id_or_mask_reg <= `TWS_REG_RESET;
			irq_status            <= `TWS_REG_RESET;
			irq_mask              <= `TWS_REG_RESET;
			irq                   <= 1'b0;
		end else begin
			// One wait cycle, then the access completes
			if ((read || write) && waitrequest) begin
				waitrequest <= 1'b0;
				readdata    <= {24'h000000, next_read};
				captured    <= (read && idx == `TWS_IDX_IRQ_STATUS) ? irq_status : 8'h00;
			end else begin
				waitrequest <= 1'b1;
			end
			if (wr_acc) begin
				case (idx)
				`TWS_IDX_CTRL:      ctrl <= writedata[7:0];
				`TWS_IDX_CMD:       reply_bit_choice <= writedata[`TWS_CMD_REPLY_BIT];
				`TWS_IDX_OWN_ID:    own_id_reg <= writedata[7:0];
				`TWS_IDX_SECOND_ID: second_id_or_mask_reg <= writedata[7:0];
				`TWS_IDX_IRQ_MASK:  irq_mask <= writedata[7:0];
				default: begin
				end
				endcase
			end
			// Only the bits already returned are cleared; new events set over the clear
			irq_status <= (rd_acc && idx == `TWS_IDX_IRQ_STATUS ? (irq_status & ~captured) : irq_status)
				| ({4'h0, set_buserr, ev_data, ev_stop, ev_match} << `TWS_IRQ_MATCH);
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule // tws_slave

// *** verification/tws_chk.sv ***
// Checker: port-level assertions of the two-wire slave.
// Assumes it is bound to tws_slave and sees only its ports.
`timescale 1ns/1ps
module tws_chk (
	// Clock and reset
	input logic        mclk,
	input logic        reset,
	// Register bus
	input logic [7:0]  address,
	input logic        read,
	input logic        write,
	input logic [3:0]  byteenable,
	input logic [31:0] writedata,
	input logic [31:0] readdata,
	input logic        waitrequest,
	input logic        irq,
	// Bus lines
	input logic        scl_i,
	input logic        scl_o,
	input logic        scl_oe,
	input logic        sda_i,
	input logic        sda_o,
	input logic        sda_oe
);
	logic [2:0] idle_cnt;
	// Cycles since the last register access, saturating
	always_ff @(posedge mclk) begin
		if (reset || read || write)
			idle_cnt <= 3'h0;
		else if (idle_cnt != 3'h7)
			idle_cnt <= idle_cnt + 3'h1;
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_bus_answer_next: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer one cycle after request");
	a_wait_one_low: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_unmapped_zero: assert property (read && waitrequest && address[1:0] != 2'h0 |=> readdata == 32'h0)
		else $error("unaligned read returned data");
	a_open_drain: assert property (!scl_o && !sda_o)
		else $error("bus line driven high");
	a_stretch_at_low: assert property ($rose(scl_oe) |-> !$past(scl_i))
		else $error("stretch began while clock line high");
	a_stretch_holds: assert property (scl_oe && idle_cnt >= 3'h2 |=> scl_oe)
		else $error("stretch released without software resume");
	a_irq_fall_read: assert property ($fell(irq) |-> idle_cnt <= 3'h3)
		else $error("interrupt dropped without register access");
	a_ack_after_resume: assert property ($rose(sda_oe) && $past(scl_oe) |-> idle_cnt <= 3'h3)
		else $error("acknowledge driven without resume");
	a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data line moved while clock line high");
	a_reset_quiet: assert property ($fell(reset) |-> waitrequest && !irq && !scl_oe && !sda_oe)
		else $error("outputs active after reset");
	c_stretch: cover property ($rose(scl_oe));
	c_ack: cover property ($rose(sda_oe));
	c_irq: cover property ($rose(irq));
endmodule // tws_chk
bind tws_slave tws_chk chk (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.irq(irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// *** verification/tws_i2c_mst.sv ***
// Bus master model driving the clock and data lines, 200 ns clock period.
// Assumes pull-ups: a released line reads 1; the lines are resolved outside.
`timescale 1ns/1ps
module tws_i2c_mst (
	// Resolved lines
	input logic  scl,
	input logic  sda,
	// Master drive, 1 = released
	output logic scl_d,
	output logic sda_d
);
	initial begin
		scl_d = 1'b1;
		sda_d = 1'b1;
	end
	// Data line falls while the clock line is high
	task automatic start();
		sda_d = 1'b1;
		#50 scl_d = 1'b1;
		#50 sda_d = 1'b0;
		#50 scl_d = 1'b0;
		#50;
	endtask
	// One bit; waits out clock stretching, bounded, before sampling
	task automatic bit_io(input logic b, output logic s);
		int n;
		sda_d = b;
		n = 0;
		#50 scl_d = 1'b1;
		while (scl !== 1'b1 && n < 400) begin
			#25 n++;
		end
		#50 s = sda;
		#50 scl_d = 1'b0;
		#50;
	endtask
	// Most significant bit first
	task automatic send(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], s);
	endtask
	// Data line rises while the clock line is high
	task automatic stop();
		sda_d = 1'b0;
		#50 scl_d = 1'b1;
		#50 sda_d = 1'b1;
		#100;
	endtask
endmodule // tws_i2c_mst

// *** verification/tws_slave_bench.sv ***
// Self-checking bench of the two-wire slave with a master model.
// Assumes the register map and flag layout of the constants header.
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_slave_bench;
	localparam logic [7:0] A_CTRL = {`TWS_IDX_CTRL, 2'h0};
	localparam logic [7:0] A_CMD  = {`TWS_IDX_CMD, 2'h0};
	localparam logic [7:0] A_FLG  = {`TWS_IDX_FLAGS, 2'h0};
	localparam logic [7:0] A_OWN  = {`TWS_IDX_OWN_ID, 2'h0};
	localparam logic [7:0] A_BYTE = {`TWS_IDX_BYTE_PORT, 2'h0};
	localparam logic [7:0] A_SEC  = {`TWS_IDX_SECOND_ID, 2'h0};
	localparam logic [7:0] A_IST  = {`TWS_IDX_IRQ_STATUS, 2'h0};
	localparam logic [7:0] A_IMSK = {`TWS_IDX_IRQ_MASK, 2'h0};
	logic        mclk;
	logic        reset;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [3:0]  byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        irq;
	logic        scl_o;
	logic        scl_oe;
	logic        sda_o;
	logic        sda_oe;
	logic        m_scl;
	logic        m_sda;
	int          n_fail;
	int          checks_done;
	logic        cause_exp;
	wire         scl = m_scl & ~scl_oe;
	wire         sda = m_sda & ~sda_oe;

	tws_slave dut (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
	tws_i2c_mst mst (.scl(scl), .sda(sda), .scl_d(m_scl), .sda_d(m_sda));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr_n, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		read <= !wr_n;
		write <= wr_n;
		// Only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 8'h00, r);
	endtask
	function automatic logic hit(input logic [6:0] id, input logic [7:0] own, input logic [7:0] sec, input logic pm);
		if (pm || (own[0] && id == `TWS_GENERAL_CALL_ID))
			return 1'b1;
		if (sec[0])
			return id == own[7:1] || id == sec[7:1];
		return ((id ^ own[7:1]) & ~sec[7:1]) == 7'h00;
	endfunction
	// Address one slave ID, answer with a refusal, then stop
	task automatic trial(input logic [7:0] own, input logic [7:0] sec, input logic [6:0] id, input logic pm,
		input logic hp);
		logic        rw;
		logic        m;
		logic        a;
		logic [31:0] r;
		rw = 1'($urandom);
		m = hit(id, own, sec, pm);
		wr(A_OWN, own);
		wr(A_SEC, sec);
		wr(A_CTRL, {2'h0, hp, 2'h0, pm, 2'h1});
		wr(A_CMD, 8'h00);
		mst.start();
		mst.send({id, rw});
		repeat (10) @(posedge mclk);
		rd(A_FLG, r);
		chk(r & 32'h61, m ? 32'h61 : {31'h0, cause_exp});
		if (m)
			chk(r[1], rw);
		chk(irq, m);
		if (m)
			wr(A_CMD, 8'h06);
		mst.bit_io(1'b1, a);
		chk(a, 1'b1);
		mst.stop();
		repeat (10) @(posedge mclk);
		if (m) begin
			rd(A_FLG, r);
			chk(r & 32'h41, hp ? 32'h40 : 32'h01);
		end
		// Cause keeps its last setter: a match, or a permitted Stop
		if (hp)
			cause_exp = 1'b0;
		else if (m)
			cause_exp = 1'b1;
		rd(A_IST, r);
		chk(r[0], m);
		repeat (3) @(posedge mclk);
		chk(irq, 1'b0);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic [7:0]  own;
		logic [7:0]  sec;
		logic [7:0]  d;
		logic [6:0]  id;
		logic        a;
		logic [7:0]  q;
		n_fail = 0;
		cause_exp = 1'b0;
		checks_done = 0;
		reset = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = 32'h0;
		void'($urandom(79260));
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		rd(A_OWN, r);
		chk(r, 32'h0);
		rd(A_SEC, r);
		chk(r, 32'h0);
		rd(A_BYTE, r);
		chk(r, 32'h0);
		rd(8'h31, r);
		chk(r, 32'h0);
		wr(A_OWN, 8'h5A);
		rd(A_OWN, r);
		chk(r, 32'h5A);
		wr(A_IMSK, 8'h01);
		for (int t = 0; t < 16; t++) begin
			own = 8'($urandom) | 8'h80;
			sec = 8'($urandom);
			case (t % 4)
				0: id = own[7:1];
				1: id = sec[7:1];
				2: id = 7'h00;
				default: id = 7'($urandom);
			endcase
			trial(own, sec, id, t == 7, 1'($urandom));
		end
		// Auto-handshake: a byte port read acknowledges and resumes
		wr(A_OWN, 8'hA4);
		wr(A_SEC, 8'h00);
		wr(A_CTRL, 8'h03);
		wr(A_CMD, 8'h00);
		mst.start();
		mst.send(8'hA4);
		repeat (10) @(posedge mclk);
		wr(A_CMD, 8'h03);
		mst.bit_io(1'b1, a);
		chk(a, 1'b0);
		d = 8'($urandom);
		mst.send(d);
		repeat (10) @(posedge mclk);
		rd(A_FLG, r);
		chk(r & 32'hA2, 32'hA0);
		rd(A_BYTE, r);
		chk(r, {24'h0, d});
		mst.bit_io(1'b1, a);
		chk(a, 1'b0);
		mst.stop();
		// Read direction: a byte port write resumes, the byte goes out MSB first
		d = 8'($urandom);
		q = 8'h00;
		mst.start();
		mst.send(8'hA5);
		repeat (10) @(posedge mclk);
		wr(A_CMD, 8'h03);
		mst.bit_io(1'b1, a);
		chk(a, 1'b0);
		repeat (10) @(posedge mclk);
		rd(A_FLG, r);
		chk(r & 32'hA2, 32'hA2);
		wr(A_BYTE, d);
		for (int i = 0; i < 8; i++) begin
			mst.bit_io(1'b1, a);
			q = {q[6:0], a};
		end
		chk(q, d);
		mst.bit_io(1'b1, a);
		mst.stop();
		rd(A_FLG, r);
		chk(r[4], 1'b1);
		// Stop inside a byte is an error only with the master side on
		for (int me = 0; me < 2; me++) begin
			wr(A_CTRL, {me[0], 7'h01});
			mst.start();
			repeat (3) mst.bit_io(1'b1, a);
			mst.stop();
			repeat (10) @(posedge mclk);
			rd(A_FLG, r);
			chk(r[2], me[0]);
			wr(A_FLG, 8'h04);
		end
		test_done();
	end
	initial begin
		#2000000;
		n_fail++;
		test_done();
	end
endmodule // tws_slave_bench
